// ===== core/axil_reg_slave.sv
`timescale 1ns/1ns
`default_nettype none
module axil_reg_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wrStrobe,
    output logic [5:0] wrIndex,
    output logic [7:0] wrData,
    output logic wrLane,
    input wire logic wrHit,
    output logic [5:0] rdIndex,
    output logic rdStrobe,
    input wire logic rdHit,
    input wire logic [7:0] rdData
);
    logic haveAw;
    logic haveW;
    logic [3:0] strb;

    // Write commits once both address and data are held
    assign wrStrobe = haveAw && haveW && !bvalid;
    assign wrLane = strb[0];
    assign rdStrobe = arvalid && arready;
    assign rdIndex = araddr[7:2];

    // Address and data are taken in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wrIndex <= '0;
            wrData <= '0;
            strb <= '0;
            bvalid <= 1'b0;
            bresp <= sequencer_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                wrIndex <= awaddr[7:2];
                haveAw <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wrData <= wdata[7:0];
                strb <= wstrb;
                haveW <= 1'b1;
                wready <= 1'b0;
            end
            if (wrStrobe) begin
                bvalid <= 1'b1;
                bresp <= wrHit ? sequencer_pkg::RESP_OKAY
                               : sequencer_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                haveAw <= 1'b0;
                haveW <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Read answers one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= sequencer_pkg::RESP_OKAY;
        end else if (rdStrobe) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rdHit ? rdData : 8'h00};
            rresp <= rdHit ? sequencer_pkg::RESP_OKAY
                           : sequencer_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule // axil_reg_slave
`default_nettype wire

// ===== core/interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
    parameter int W = 17
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    input wire logic tick,
    output logic busy,
    output logic done
);
    logic [W-1:0] count;

    // Load wins over a running count; zero finishes next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                count <= value;
                busy <= (value != '0);
                done <= (value == '0);
            end else if (busy && tick) begin
                count <= count - 1'b1;
                if (count == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // interval_timer
`default_nettype wire

// ===== core/pwm_shutdown_fault_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_shutdown_fault_sequencer #(
    parameter int ADDR_W = 8,
    parameter int TICK_CYCLES = sequencer_pkg::TICK_CYCLES,
    parameter int TRIM_CYCLES = sequencer_pkg::TRIM_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic powerDownPinN,
    input wire logic backEndError,
    output logic [3:0] pwmRun,
    output logic rampActive,
    output logic powerStageReset,
    output logic headphoneEnable,
    output logic factoryTrimSelect
);
    localparam int TW = sequencer_pkg::TIME_W;

    logic wrStrobe;
    logic [5:0] wrIndex;
    logic [7:0] wrData;
    logic wrLane;
    logic wrHit;
    logic [5:0] rdIndex;
    logic rdStrobe;
    logic rdHit;
    logic [7:0] rdData;
    logic [7:0] groupMask;
    logic [7:0] rampCfg;
    logic [7:0] retryCfg;
    logic [7:0] ctrlReg;
    logic trimDisable;
    logic trimDone;
    logic trimBusy;
    logic [15:0] trimCount;
    logic pdnMeta;
    logic pdnSync;
    logic errMeta;
    logic errSync;
    logic prevShut;
    logic prevPdn;
    logic shutReq;
    logic change;
    logic [15:0] tickCount;
    logic tick;
    sequencer_pkg::seq_state_type state;
    sequencer_pkg::seq_state_type next_state;
    logic rampLoad;
    logic retryLoad;
    logic hpLoad;
    logic rampDone;
    logic retryDone;
    logic hpDone;
    logic [TW-1:0] rampValue;
    logic [TW-1:0] retryValue;
    logic [TW-1:0] hpValue;
    logic [3:0] runMask;
    logic [7:0] statusReg;

    axil_reg_slave #(.ADDR_W(ADDR_W)) busSlave (
        .clk(clk),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrStrobe(wrStrobe),
        .wrIndex(wrIndex),
        .wrData(wrData),
        .wrLane(wrLane),
        .wrHit(wrHit),
        .rdIndex(rdIndex),
        .rdStrobe(rdStrobe),
        .rdHit(rdHit),
        .rdData(rdData)
    );

    // Register decode: indices 0x19 to 0x1e are mapped
    assign wrHit = (wrIndex >= sequencer_pkg::IDX_GROUP) &&
                   (wrIndex <= sequencer_pkg::IDX_STATUS);
    assign rdHit = (rdIndex >= sequencer_pkg::IDX_GROUP) &&
                   (rdIndex <= sequencer_pkg::IDX_STATUS);

    // Read view of each register
    always_comb begin
        unique case (rdIndex)
            sequencer_pkg::IDX_GROUP: rdData = groupMask;
            sequencer_pkg::IDX_RAMP: rdData = rampCfg;
            sequencer_pkg::IDX_TRIM: begin
                rdData = 8'h00;
                rdData[sequencer_pkg::TRIM_RSVD_BIT] = 1'b1;
                rdData[sequencer_pkg::TRIM_DONE_BIT] = trimDone;
                rdData[sequencer_pkg::TRIM_DIS_BIT] = trimDisable;
            end
            sequencer_pkg::IDX_RETRY: rdData = retryCfg;
            sequencer_pkg::IDX_CTRL: rdData = ctrlReg;
            sequencer_pkg::IDX_STATUS: rdData = statusReg;
            default: rdData = 8'h00;
        endcase
    end

    // Writable configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            groupMask <= sequencer_pkg::GROUP_RESET;
            rampCfg <= sequencer_pkg::RAMP_RESET;
            retryCfg <= sequencer_pkg::RETRY_RESET;
            ctrlReg <= sequencer_pkg::CTRL_RESET;
        end else if (wrStrobe && wrLane) begin
            unique case (wrIndex)
                sequencer_pkg::IDX_GROUP: groupMask <= wrData;
                sequencer_pkg::IDX_RAMP: rampCfg <= wrData;
                sequencer_pkg::IDX_RETRY: retryCfg <= wrData;
                sequencer_pkg::IDX_CTRL: ctrlReg <= wrData;
                default: ;
            endcase
        end
    end

    // Oscillator trim: a zero write selects and runs the factory trim
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trimDisable <= 1'b1;
            trimDone <= 1'b0;
            trimBusy <= 1'b0;
            trimCount <= '0;
        end else if (wrStrobe && wrLane &&
                     wrIndex == sequencer_pkg::IDX_TRIM) begin
            trimDisable <= wrData[sequencer_pkg::TRIM_DIS_BIT];
            if (wrData == sequencer_pkg::TRIM_START_VALUE) begin
                trimBusy <= 1'b1;
                trimDone <= 1'b0;
                trimCount <= 16'(TRIM_CYCLES - 1);
            end
        end else if (trimBusy) begin
            trimCount <= trimCount - 1'b1;
            if (trimCount == 16'h0000) begin
                trimBusy <= 1'b0;
                trimDone <= 1'b1;
            end
        end
    end

    // Pin and power stage inputs pass two flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pdnMeta <= 1'b1;
            pdnSync <= 1'b1;
            errMeta <= 1'b0;
            errSync <= 1'b0;
        end else begin
            pdnMeta <= powerDownPinN;
            pdnSync <= pdnMeta;
            errMeta <= backEndError;
            errSync <= errMeta;
        end
    end

    // Remember shutdown sources to spot a change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevShut <=
                sequencer_pkg::CTRL_RESET[sequencer_pkg::CTRL_SHUT_BIT];
            prevPdn <= 1'b1;
        end else begin
            prevShut <= ctrlReg[sequencer_pkg::CTRL_SHUT_BIT];
            prevPdn <= pdnSync;
        end
    end

    assign shutReq = ctrlReg[sequencer_pkg::CTRL_SHUT_BIT] || !pdnSync;
    assign change = (prevShut != ctrlReg[sequencer_pkg::CTRL_SHUT_BIT]) ||
                    (prevPdn != pdnSync);

    // Timebase of one tick per 0.1 ms
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCount <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tickCount == 16'(TICK_CYCLES - 1));
            if (tickCount == 16'(TICK_CYCLES - 1)) begin
                tickCount <= '0;
            end else begin
                tickCount <= tickCount + 1'b1;
            end
        end
    end

    // Period lookups for ramp, retry and headphone timers
    always_comb begin
        rampValue = sequencer_pkg::ramp_ticks(rampCfg[4:0]);
        if (rampCfg[sequencer_pkg::RAMP_OFF_BIT] ||
            rampCfg[4:0] < sequencer_pkg::RAMP_MIN_CODE) begin
            rampValue = '0;
        end
        retryValue = sequencer_pkg::retry_ticks(retryCfg[3:0]);
        hpValue = TW'(retryCfg[7:4] * sequencer_pkg::HP_STEP_TICKS);
    end

    // Sequencer: ramps around shutdown, stops on back-end error
    always_comb begin
        next_state = state;
        rampLoad = 1'b0;
        retryLoad = 1'b0;
        unique case (state)
            sequencer_pkg::OFF: begin
                if (change && !shutReq) begin
                    next_state = sequencer_pkg::RAMP_UP;
                    rampLoad = 1'b1;
                end
            end
            sequencer_pkg::RAMP_UP, sequencer_pkg::RAMP_DOWN: begin
                if (change) begin
                    next_state = shutReq ? sequencer_pkg::RAMP_DOWN
                                         : sequencer_pkg::RAMP_UP;
                    rampLoad = 1'b1;
                end else if (rampDone) begin
                    next_state = (state == sequencer_pkg::RAMP_UP) ?
                                 sequencer_pkg::RUN : sequencer_pkg::OFF;
                end
            end
            sequencer_pkg::RUN: begin
                if (change) begin
                    next_state = sequencer_pkg::RAMP_DOWN;
                    rampLoad = 1'b1;
                end
            end
            sequencer_pkg::FAULT: begin
                if (retryDone) begin
                    next_state = shutReq ? sequencer_pkg::OFF
                                         : sequencer_pkg::RAMP_UP;
                    rampLoad = !shutReq;
                end
            end
            default: next_state = sequencer_pkg::OFF;
        endcase
        if (errSync && state != sequencer_pkg::OFF &&
            state != sequencer_pkg::FAULT) begin
            next_state = sequencer_pkg::FAULT;
            rampLoad = 1'b0;
            retryLoad = 1'b1;
        end
    end

    assign hpLoad = (next_state == sequencer_pkg::RUN) &&
                    (state != sequencer_pkg::RUN);

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sequencer_pkg::OFF;
        end else begin
            state <= next_state;
        end
    end

    interval_timer #(.W(TW)) rampTimer (
        .clk(clk),
        .rst(rst),
        .load(rampLoad),
        .value(rampValue),
        .tick(tick),
        .busy(),
        .done(rampDone)
    );

    interval_timer #(.W(TW)) retryTimer (
        .clk(clk),
        .rst(rst),
        .load(retryLoad),
        .value(retryValue),
        .tick(tick),
        .busy(),
        .done(retryDone)
    );

    interval_timer #(.W(TW)) hpTimer (
        .clk(clk),
        .rst(rst),
        .load(hpLoad),
        .value(hpValue),
        .tick(tick),
        .busy(),
        .done(hpDone)
    );

    // Group members stay stopped unless the group bit is set
    assign runMask = ctrlReg[sequencer_pkg::CTRL_GROUP_BIT] ? 4'hf
                                                     : ~groupMask[3:0];

    // Registered outputs toward the power stage and headphone driver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwmRun <= 4'h0;
            rampActive <= 1'b0;
            powerStageReset <= 1'b0;
            headphoneEnable <= 1'b0;
            factoryTrimSelect <= 1'b0;
        end else begin
            pwmRun <= (state == sequencer_pkg::RAMP_UP ||
                       state == sequencer_pkg::RUN ||
                       state == sequencer_pkg::RAMP_DOWN) ? runMask
                                                          : 4'h0;
            rampActive <= (state == sequencer_pkg::RAMP_UP ||
                           state == sequencer_pkg::RAMP_DOWN);
            powerStageReset <= (state == sequencer_pkg::FAULT);
            if (state != sequencer_pkg::RUN) begin
                headphoneEnable <= 1'b0;
            end else if (hpDone) begin
                headphoneEnable <= 1'b1;
            end
            factoryTrimSelect <= !trimDisable;
        end
    end

    assign statusReg = {headphoneEnable, powerStageReset, rampActive,
                        trimBusy, pwmRun};
endmodule // pwm_shutdown_fault_sequencer
`default_nettype wire

// ===== core/sequencer_pkg.sv
`default_nettype none
package sequencer_pkg;
    // Clock and timebase
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_TIME_US = 100;
    localparam int TICK_CYCLES = TICK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int TRIM_CYCLES = 16;
    localparam int TIME_W = 18;
    // Headphone delay step of 2 ms in timebase ticks
    localparam int HP_STEP_MS = 2;
    localparam int HP_STEP_TICKS = HP_STEP_MS * 1000 / TICK_TIME_US;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_GROUP = 6'h19;
    localparam logic [5:0] IDX_RAMP = 6'h1a;
    localparam logic [5:0] IDX_TRIM = 6'h1b;
    localparam logic [5:0] IDX_RETRY = 6'h1c;
    localparam logic [5:0] IDX_CTRL = 6'h1d;
    localparam logic [5:0] IDX_STATUS = 6'h1e;

    // Reset values
    localparam logic [7:0] GROUP_RESET = 8'h30;
    localparam logic [7:0] RAMP_RESET = 8'h0f;
    localparam logic [7:0] RETRY_RESET = 8'h52;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    // Field positions
    localparam int RAMP_OFF_BIT = 7;
    localparam int TRIM_RSVD_BIT = 7;
    localparam int TRIM_DONE_BIT = 6;
    localparam int TRIM_DIS_BIT = 1;
    localparam int CTRL_SHUT_BIT = 0;
    localparam int CTRL_GROUP_BIT = 5;
    localparam logic [4:0] RAMP_MIN_CODE = 5'h08;
    localparam logic [7:0] TRIM_START_VALUE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OFF, RAMP_UP, RUN, RAMP_DOWN, FAULT
    } seq_state_type;

    // 50% duty period in 0.1 ms ticks per code
    function automatic logic [TIME_W-1:0] ramp_ticks(input logic [4:0] c);
        unique case (c)
            5'h08: ramp_ticks = 18'd165;
            5'h09: ramp_ticks = 18'd239;
            5'h0a: ramp_ticks = 18'd314;
            5'h0b: ramp_ticks = 18'd404;
            5'h0c: ramp_ticks = 18'd539;
            5'h0d: ramp_ticks = 18'd703;
            5'h0e: ramp_ticks = 18'd942;
            5'h0f: ramp_ticks = 18'd1257;
            5'h10: ramp_ticks = 18'd1646;
            5'h11: ramp_ticks = 18'd2394;
            5'h12: ramp_ticks = 18'd3142;
            5'h13: ramp_ticks = 18'd4039;
            5'h14: ramp_ticks = 18'd5386;
            5'h15: ramp_ticks = 18'd7031;
            5'h16: ramp_ticks = 18'd9425;
            5'h17: ramp_ticks = 18'd12566;
            5'h18: ramp_ticks = 18'd17281;
            5'h19: ramp_ticks = 18'd25136;
            5'h1a: ramp_ticks = 18'd32991;
            5'h1b: ramp_ticks = 18'd42417;
            5'h1c: ramp_ticks = 18'd56556;
            5'h1d: ramp_ticks = 18'd73837;
            5'h1e: ramp_ticks = 18'd98973;
            5'h1f: ramp_ticks = 18'd131964;
            default: ramp_ticks = 18'd0;
        endcase
    endfunction

    // Back-end reset wait in 0.1 ms ticks per code
    function automatic logic [TIME_W-1:0] retry_ticks(input logic [3:0] c);
        unique case (c)
            4'h3: retry_ticks = 18'd4490;
            4'h4: retry_ticks = 18'd5980;
            4'h5: retry_ticks = 18'd7480;
            4'h6: retry_ticks = 18'd8980;
            4'h7: retry_ticks = 18'd10470;
            4'h8: retry_ticks = 18'd11970;
            4'h9: retry_ticks = 18'd13460;
            4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: retry_ticks = 18'd14960;
            default: retry_ticks = 18'd2990;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== tb/power_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic faultReq,
    input wire logic powerStageReset,
    output logic backEndError
);
    // Error stands until the sequencer resets the stage
    always_ff @(posedge clk or posedge rst)
        if (rst) backEndError <= 1'b0;
        else if (faultReq) backEndError <= 1'b1;
        else if (powerStageReset) backEndError <= 1'b0;
endmodule // power_stage_model
`default_nettype wire

// ===== tb/pwm_shutdown_fault_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_shutdown_fault_sequencer_tb_top;
    localparam int TK = 2;
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic powerDownPinN = 1'b1, faultReq = 1'b0, backEndError;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, q, lfsr = 32'hc253;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, rampActive;
    logic powerStageReset, headphoneEnable, factoryTrimSelect;
    logic [3:0] pwmRun, m;
    logic [7:0] da[4] = '{8'h64, 8'h68, 8'h6c, 8'h70};
    logic [7:0] dv[4] = '{8'h30, 8'h0f, 8'h82, 8'h52};
    logic [3:0] cd[3] = '{4'h0, 4'h3, 4'h9};
    int failures = 0, num_checks = 0, n, x;
    always #50 clk = ~clk;
    pwm_shutdown_fault_sequencer #(.TICK_CYCLES(TK), .TRIM_CYCLES(4))
        pwm_shutdown_fault_sequencer_inst (.clk, .rst, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .powerDownPinN, .backEndError, .pwmRun, .rampActive,
        .powerStageReset, .headphoneEnable, .factoryTrimSelect);
    power_stage_model power_stage_model_inst (.clk, .rst, .faultReq,
        .powerStageReset, .backEndError);
    function automatic logic [31:0] nxt(logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int rt(logic [3:0] c);
        rt = (c == 4'h3) ? 4490 : (c == 4'h9) ? 13460 : 2990;
    endfunction
    function automatic logic near(int a, int b);
        near = a >= b - 8 && a <= b + 8;
    endfunction
    function automatic logic sig(int s);
        sig = s == 0 ? rampActive : s == 1 ? powerStageReset : headphoneEnable;
    endfunction
    task automatic conclude();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One bus transfer; ready stands from the request until the answer
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        logic ta, tw, tv, tr;
        int i;
        @(posedge clk);
        if (w) begin
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            ta = (awvalid && awready) || (arvalid && arready);
            tw = wvalid && wready;
            tv = w ? bvalid : rvalid;
            tr = w ? bready : rready;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge clk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (tw) wvalid <= 1'b0;
            if (tv && tr) begin
                bready <= 1'b0;
                rready <= 1'b0;
                break;
            end
        end
        if (i == 60) begin
            failures++;
            conclude();
        end
    endtask
    // Cycles until the chosen output reaches the level
    task automatic span(input int s, input logic v, output int c);
        for (c = 0; c < 40000; c++) begin
            @(negedge clk);
            if (sig(s) === v) break;
        end
        if (c == 40000) begin
            failures++;
            conclude();
        end
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, da[i], 8'h0);
            chk(q, {24'h0, dv[i]});
        end
        chk(factoryTrimSelect, 1'b0);
        bus(1'b1, 8'h6c, 8'h00);
        chk(r, 2'h0);
        repeat (20) @(posedge clk);
        bus(1'b0, 8'h6c, 8'h0);
        chk(q, 32'hc0);
        chk(factoryTrimSelect, 1'b1);
        bus(1'b0, 8'h10, 8'h0);
        chk(r, 2'h2);
        chk(q, 32'h0);
        // Group mask with the ramp off
        bus(1'b1, 8'h68, 8'h80);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            m = (i == 0) ? 4'ha : lfsr[3:0];
            bus(1'b1, 8'h74, 8'h01);
            bus(1'b1, 8'h64, {4'h3, m});
            bus(1'b1, 8'h74, 8'h00);
            repeat (10) @(posedge clk);
            chk(pwmRun, {28'h0, ~m});
        end
        bus(1'b1, 8'h74, 8'h20);
        repeat (10) @(posedge clk);
        chk(pwmRun, 4'hf);
        bus(1'b0, 8'h78, 8'h0);
        chk(q, 32'h0f);
        // Soft ramp on leaving shutdown and on the pin
        bus(1'b1, 8'h74, 8'h01);
        bus(1'b1, 8'h68, 8'h08);
        for (int i = 0; i < 2; i++) begin
            if (i == 0) bus(1'b1, 8'h74, 8'h00);
            else powerDownPinN <= 1'b0;
            span(0, 1'b1, x);
            span(0, 1'b0, n);
            chk(near(n, 165 * TK), 1'b1);
            @(posedge clk);
        end
        powerDownPinN <= 1'b1;
        span(0, 1'b1, x);
        span(0, 1'b0, x);
        bus(1'b1, 8'h68, 8'h80);
        // Back-end fault, retry wait, then headphone delay
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            bus(1'b1, 8'h70, {lfsr[3:0], cd[i]});
            @(posedge clk);
            faultReq <= 1'b1;
            @(posedge clk);
            faultReq <= 1'b0;
            span(1, 1'b1, x);
            span(1, 1'b0, n);
            chk(near(n, rt(cd[i]) * TK), 1'b1);
            span(2, 1'b1, n);
            chk(near(n, lfsr[3:0] * 20 * TK), 1'b1);
        end
        conclude();
    end
endmodule // pwm_shutdown_fault_sequencer_tb_top
`default_nettype wire

// ===== tb/sequencer_props.sv
`timescale 1ns/1ns
`default_nettype none
module sequencer_props #(
    parameter int ADDR_W = 8,
    parameter int TICK_CYCLES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic backEndError,
    input wire logic [3:0] pwmRun,
    input wire logic powerStageReset,
    input wire logic headphoneEnable
);
    localparam int RETRY_MIN = 2990 * TICK_CYCLES - 4;
    int psCount;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence arTake; arvalid && arready; endsequence
    sequence rAnswer; !arready && rvalid; endsequence
    sequence errRun; backEndError && pwmRun != 4'h0; endsequence
    // Length of the current stage reset hold
    always_ff @(posedge clk or posedge rst)
        if (rst) psCount <= 0;
        else psCount <= powerStageReset ? psCount + 1 : 0;
    rd_answer_a: assert property (arTake |=> rAnswer)
        else $error("read answer out of step");
    r_hold_a: assert property (rvalid |=>
        ($past(rready) ? !rvalid : (rvalid && $stable(rdata))))
        else $error("read response not held or not released");
    b_hold_a: assert property (bvalid |=>
        ($past(bready) ? !bvalid : (bvalid && $stable(bresp))))
        else $error("write response not held or not released");
    w_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response open");
    rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    fault_halt_a: assert property (
        powerStageReset |-> pwmRun == 4'h0 && !headphoneEnable)
        else $error("output active during fault");
    fault_entry_a: assert property (
        errRun |-> ##[1:6] powerStageReset)
        else $error("fault not entered");
    retry_min_a: assert property (
        $fell(powerStageReset) |-> psCount >= RETRY_MIN)
        else $error("retry wait too short");
endmodule // sequencer_props
bind pwm_shutdown_fault_sequencer sequencer_props #(.ADDR_W(ADDR_W),
    .TICK_CYCLES(TICK_CYCLES)) sequencer_props_inst (.clk, .rst, .awready,
    .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
    .rdata, .backEndError, .pwmRun, .powerStageReset, .headphoneEnable);
`default_nettype wire
